// file: hw/csdma_pend.sv
`timescale 1ns/1ps
module csdma_pend
(
   input wire logic clk, // System clock
   input wire logic reset_n, // Async reset
   input wire logic trig, // Request event
   input wire logic arm, // Channel may accept
   input wire logic take, // Request being served
   output logic pending // Request held
);
   import csdma_pkg::*;

   typedef struct packed {
      logic pend;
   } csdma_pend_s;

   csdma_pend_s st;
   csdma_pend_s next_st;

   // New event wins over service in the same cycle
   always_comb
   begin
      next_st = st;
      next_st.pend = arm & (trig | (st.pend & ~take));
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign pending = st.pend;
endmodule // csdma_pend

// file: hw/csdma_prio.sv
`timescale 1ns/1ps
module csdma_prio
(
   input wire logic [csdma_pkg::NCH-1:0] req, // Pending per channel
   output logic any, // Some channel pending
   output logic [1:0] sel // Winning channel
);
   import csdma_pkg::*;

   // Lowest index wins
   always_comb
   begin
      any = |req;
      sel = 2'h0;
      for (int i = NCH - 1; i >= 0; i--)
      begin
         if (req[i])
            sel = i[1:0];
      end
   end
endmodule // csdma_prio

// file: hw/csdma_top.sv
`timescale 1ns/1ps
module csdma_top
(
   input wire logic clk, // System clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [csdma_pkg::CR_AW-1:0] cr_addr, // Control register address
   input wire logic [csdma_pkg::CR_DW-1:0] cr_wdata, // Control register write data
   input wire logic cr_load, // Control register load strobe
   input wire logic cr_read, // Control register read strobe
   output logic [csdma_pkg::CR_DW-1:0] cr_rdata, // Read data, cycle after strobe
   input wire logic [csdma_pkg::NCAUSE-1:0] irq_cause, // Peripheral request pulses
   output logic cpu_hold, // Bus taken from processor
   output logic [csdma_pkg::MEM_AW-1:0] mem_addr, // Memory address
   output logic mem_rd, // Memory read strobe
   output logic mem_wr, // Memory write strobe
   output logic mem_word, // Unit is 16 bits
   output logic [csdma_pkg::MEM_DW-1:0] mem_wdata, // Memory write data
   input wire logic [csdma_pkg::MEM_DW-1:0] mem_rdata, // Read data, cycle after mem_rd
   output logic [csdma_pkg::NCH-1:0] done_irq, // Completion pulse per channel
   output logic hs_irq_block // High-speed interrupts unavailable
);
   import csdma_pkg::*;

   typedef struct packed {
      csdma_fsm_e fsm;
      logic [1:0] cur;
      csdma_chan_s [NCH-1:0] ch;
      logic [MEM_AW-1:0] addr;
      logic rd;
      logic wr;
      logic word;
      logic [MEM_DW-1:0] wdata;
      logic hold;
      logic [NCH-1:0] done;
      logic [CR_DW-1:0] rdata;
      logic hsb;
   } csdma_top_s;

   csdma_top_s st;
   csdma_top_s next_st;

   logic [NCH-1:0] arm;
   logic [NCH-1:0] trig;
   logic [NCH-1:0] take;
   logic [NCH-1:0] pend;
   logic any;
   logic [1:0] sel;
   logic [1:0] cr_ch;
   logic [4:0] cr_off;
   logic cr_chan_space;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   assign cr_ch = cr_addr[CH_SEL_LSB +: 2];
   assign cr_off = cr_addr[4:0];
   assign cr_chan_space = ~cr_addr[STAT_SEL_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Request capture per channel
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         // Interrupt enables play no part here
         arm[i] = ((st.ch[i].mode == MODE_SINGLE) || (st.ch[i].mode == MODE_REPEAT))
                  && (st.ch[i].count != CNT_ZERO);
         trig[i] = 1'b0;
         if (st.ch[i].cause != CAUSE_SOFT)
            trig[i] = irq_cause[st.ch[i].cause];
         else if (cr_load && cr_chan_space && (cr_ch == i[1:0]) && (cr_off == OFF_CTRL)
                  && cr_wdata[CTRL_SW_BIT]
                  && (cr_wdata[CTRL_CAUSE_LSB +: CAUSE_W] == CAUSE_SOFT))
            trig[i] = 1'b1;
         take[i] = (st.fsm == S_IDLE) && any && (sel == i[1:0]);
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_pend
         csdma_pend u_pend
         (
            .clk(clk),
            .reset_n(reset_n),
            .trig(trig[g]),
            .arm(arm[g]),
            .take(take[g]),
            .pending(pend[g])
         );
      end
   endgenerate

   csdma_prio u_prio
   (
      .req(pend),
      .any(any),
      .sel(sel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine and register file
   always_comb
   begin
      csdma_chan_s c;
      logic [MEM_AW-1:0] src;
      logic [MEM_AW-1:0] dst;
      c = st.ch[st.cur];
      // Exactly one side steps forward
      src = c.fwd_dest ? c.fix : c.fwd;
      dst = c.fwd_dest ? c.fwd : c.fix;
      next_st = st;
      next_st.done = '0;
      next_st.rd = 1'b0;
      next_st.wr = 1'b0;
      next_st.rdata = '0;

      unique case (st.fsm)
         S_IDLE:
         begin
            if (any)
            begin
               // Take the bus ahead of the processor
               next_st.cur = sel;
               next_st.hold = 1'b1;
               next_st.rd = 1'b1;
               next_st.addr = st.ch[sel].fwd_dest ? st.ch[sel].fix : st.ch[sel].fwd;
               next_st.word = st.ch[sel].word;
               next_st.fsm = S_READ;
            end
         end
         S_READ:
         begin
            next_st.fsm = S_CAPT;
         end
         S_CAPT:
         begin
            // Source data valid now
            next_st.wr = 1'b1;
            next_st.addr = dst;
            next_st.wdata = mem_rdata;
            next_st.fsm = S_WRITE;
         end
         S_WRITE:
         begin
            // One unit only, then the processor gets the bus back
            next_st.hold = 1'b0;
            next_st.fsm = S_IDLE;
            c.count = c.count - CNT_ONE;
            c.fwd = c.fwd + (c.word ? STEP_WORD : STEP_BYTE);
            if (st.ch[st.cur].count == CNT_ONE)
            begin
               next_st.done[st.cur] = 1'b1;
               if (c.mode == MODE_REPEAT)
               begin
                  // Zero reload leaves count at zero and stops
                  c.count = c.reload;
                  c.fwd = c.arel;
               end
            end
            next_st.ch[st.cur] = c;
         end
         default:
         begin
            next_st.fsm = S_IDLE;
         end
      endcase

      // Control register load; software wins over the engine's update
      if (cr_load && cr_chan_space)
      begin
         unique case (cr_off)
            OFF_CTRL:
            begin
               next_st.ch[cr_ch].mode = cr_wdata[CTRL_MODE_LSB +: 2];
               next_st.ch[cr_ch].word = cr_wdata[CTRL_WORD_BIT];
               next_st.ch[cr_ch].fwd_dest = cr_wdata[CTRL_FDST_BIT];
               next_st.ch[cr_ch].cause = cr_wdata[CTRL_CAUSE_LSB +: CAUSE_W];
            end
            OFF_COUNT:
            begin
               next_st.ch[cr_ch].count = cr_wdata[CNT_W-1:0];
            end
            OFF_RELOAD:
            begin
               next_st.ch[cr_ch].reload = cr_wdata[CNT_W-1:0];
            end
            OFF_FWD:
            begin
               next_st.ch[cr_ch].fwd = cr_wdata[MEM_AW-1:0];
            end
            OFF_FIX:
            begin
               next_st.ch[cr_ch].fix = cr_wdata[MEM_AW-1:0];
            end
            OFF_AREL:
            begin
               next_st.ch[cr_ch].arel = cr_wdata[MEM_AW-1:0];
            end
            default:
            begin
            end
         endcase
      end

      // Read data for the cycle after the strobe
      if (cr_read)
      begin
         if (cr_chan_space)
         begin
            unique case (cr_off)
               OFF_CTRL:
               begin
                  // Software request bit always reads zero
                  next_st.rdata[CTRL_MODE_LSB +: 2] = st.ch[cr_ch].mode;
                  next_st.rdata[CTRL_WORD_BIT] = st.ch[cr_ch].word;
                  next_st.rdata[CTRL_FDST_BIT] = st.ch[cr_ch].fwd_dest;
                  next_st.rdata[CTRL_CAUSE_LSB +: CAUSE_W] = st.ch[cr_ch].cause;
                  next_st.rdata[CTRL_PEND_BIT] = pend[cr_ch];
               end
               OFF_COUNT:
               begin
                  next_st.rdata[CNT_W-1:0] = st.ch[cr_ch].count;
               end
               OFF_RELOAD:
               begin
                  next_st.rdata[CNT_W-1:0] = st.ch[cr_ch].reload;
               end
               OFF_FWD:
               begin
                  next_st.rdata[MEM_AW-1:0] = st.ch[cr_ch].fwd;
               end
               OFF_FIX:
               begin
                  next_st.rdata[MEM_AW-1:0] = st.ch[cr_ch].fix;
               end
               OFF_AREL:
               begin
                  next_st.rdata[MEM_AW-1:0] = st.ch[cr_ch].arel;
               end
               default:
               begin
               end
            endcase
         end
         else if (cr_addr == ADDR_STATUS)
         begin
            next_st.rdata[STAT_BUSY_BIT] = st.hold;
            next_st.rdata[STAT_CH_LSB +: 2] = st.cur;
            next_st.rdata[STAT_HSB_BIT] = st.hsb;
         end
      end

      // Upper channels borrow the high-speed interrupt storage
      next_st.hsb = (next_st.ch[2].mode != MODE_OFF)
                    || (next_st.ch[3].mode != MODE_OFF);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.fsm <= S_IDLE;
         for (int i = 0; i < NCH; i++)
            st.ch[i] <= CHAN_RST;
      end
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from state
   assign cr_rdata = st.rdata;
   assign cpu_hold = st.hold;
   assign mem_addr = st.addr;
   assign mem_rd = st.rd;
   assign mem_wr = st.wr;
   assign mem_word = st.word;
   assign mem_wdata = st.wdata;
   assign done_irq = st.done;
   assign hs_irq_block = st.hsb;

endmodule // csdma_top

// file: shared/csdma_pkg.sv
package csdma_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and sizes
   localparam int NCH = 4;
   localparam int CR_AW = 8;
   localparam int CR_DW = 32;
   localparam int MEM_AW = 24;
   localparam int MEM_DW = 16;
   localparam int CNT_W = 16;
   localparam int CAUSE_W = 5;
   localparam int NCAUSE = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, per channel block and status
   localparam logic [1:0] CH_FIELD_W = 2'h2;
   localparam int CH_SEL_LSB = 5;
   localparam int STAT_SEL_BIT = 7;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_COUNT = 5'h04;
   localparam logic [4:0] OFF_RELOAD = 5'h08;
   localparam logic [4:0] OFF_FWD = 5'h0C;
   localparam logic [4:0] OFF_FIX = 5'h10;
   localparam logic [4:0] OFF_AREL = 5'h14;
   localparam logic [CR_AW-1:0] ADDR_STATUS = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // Control and status word fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WORD_BIT = 2;
   localparam int CTRL_FDST_BIT = 3;
   localparam int CTRL_CAUSE_LSB = 8;
   localparam int CTRL_SW_BIT = 13;
   localparam int CTRL_PEND_BIT = 15;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CH_LSB = 1;
   localparam int STAT_HSB_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Codes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_REPEAT = 2'h3;
   localparam logic [CAUSE_W-1:0] CAUSE_SOFT = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [MEM_AW-1:0] STEP_BYTE = 24'h000001;
   localparam logic [MEM_AW-1:0] STEP_WORD = 24'h000002;

   typedef enum logic [1:0] {S_IDLE, S_READ, S_CAPT, S_WRITE} csdma_fsm_e;

   typedef struct packed {
      logic [1:0] mode;
      logic word;
      logic fwd_dest;
      logic [CAUSE_W-1:0] cause;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] reload;
      logic [MEM_AW-1:0] fwd;
      logic [MEM_AW-1:0] fix;
      logic [MEM_AW-1:0] arel;
   } csdma_chan_s;

   localparam csdma_chan_s CHAN_RST = '0;

endpackage

// file: tb/csdma_mem.sv
`timescale 1ns/1ps
module csdma_mem
(
   input wire logic clk, // System clock
   input wire logic mem_rd, // Read strobe
   input wire logic [csdma_pkg::MEM_AW-1:0] mem_addr, // Address
   output logic [csdma_pkg::MEM_DW-1:0] mem_rdata // Data, cycle after strobe
);
   import csdma_pkg::*;
   initial mem_rdata = 16'h0000;
   always @(posedge clk)
   begin
      if (mem_rd)
         mem_rdata <= {8'hA5, mem_addr[7:0]};
      else
         mem_rdata <= ~mem_rdata; // Released bus inverts its data each cycle
   end
endmodule // csdma_mem

// file: tb/csdma_props.sv
`timescale 1ns/1ps
module csdma_props
(
   input wire logic clk, // System clock
   input wire logic reset_n, // Async reset
   input wire logic [csdma_pkg::CR_AW-1:0] cr_addr, // Register address
   input wire logic [csdma_pkg::CR_DW-1:0] cr_wdata, // Register write data
   input wire logic cr_load, // Load strobe
   input wire logic cr_read, // Read strobe
   input wire logic [csdma_pkg::CR_DW-1:0] cr_rdata, // Read data
   input wire logic [csdma_pkg::NCAUSE-1:0] irq_cause, // Request pulses
   input wire logic cpu_hold, // Bus taken
   input wire logic [csdma_pkg::MEM_AW-1:0] mem_addr, // Memory address
   input wire logic mem_rd, // Memory read
   input wire logic mem_wr, // Memory write
   input wire logic mem_word, // Word unit
   input wire logic [csdma_pkg::MEM_DW-1:0] mem_wdata, // Write data
   input wire logic [csdma_pkg::MEM_DW-1:0] mem_rdata, // Read data
   input wire logic [csdma_pkg::NCH-1:0] done_irq, // Completion pulses
   input wire logic hs_irq_block // High-speed block
);
   import csdma_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_read;
      mem_rd && cpu_hold && !mem_wr;
   endsequence
   sequence s_write;
      !mem_rd && !mem_wr && cpu_hold ##1 mem_wr && cpu_hold;
   endsequence
   a_read_then_write: assert property (s_read |=> s_write)
      else $error("read not followed by write");
   a_hold_three: assert property ($rose(cpu_hold) |-> cpu_hold [*3] ##1 !cpu_hold)
      else $error("bus hold not three cycles");
   a_hold_starts_read: assert property ($rose(cpu_hold) |-> s_read)
      else $error("hold began without a read");
   a_access_under_hold: assert property ((mem_rd || mem_wr) |-> cpu_hold)
      else $error("memory access without bus hold");
   a_unit_size_kept: assert property (mem_wr |-> mem_word == $past(mem_word, 2))
      else $error("unit size changed within a transfer");
   a_done_after_write: assert property (|done_irq |-> $past(mem_wr))
      else $error("completion without a write");
   a_done_one_chan: assert property ($onehot0(done_irq))
      else $error("two completions at once");
   a_rdata_idle: assert property (!$past(cr_read) |-> cr_rdata == '0)
      else $error("read data outside its cycle");
   a_sw_bit_zero: assert property ($past(cr_read) && ($past(cr_addr) & 8'h9F) == 8'h00
      |-> !cr_rdata[CTRL_SW_BIT])
      else $error("software request bit read as one");
endmodule // csdma_props
bind csdma_top csdma_props u_props (.clk(clk), .reset_n(reset_n), .cr_addr(cr_addr), .cr_wdata(cr_wdata),
   .cr_load(cr_load), .cr_read(cr_read), .cr_rdata(cr_rdata), .irq_cause(irq_cause), .cpu_hold(cpu_hold),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_word(mem_word), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata), .done_irq(done_irq), .hs_irq_block(hs_irq_block));

// file: tb/csdma_top_test.sv
`timescale 1ns/1ps
module csdma_top_test;
   import csdma_pkg::*;
   logic clk, reset_n, cr_load, cr_read, mem_rd, mem_wr, mem_word, cpu_hold, hs_irq_block;
   logic [CR_AW-1:0] cr_addr;
   logic [CR_DW-1:0] cr_wdata, cr_rdata, rd;
   logic [NCAUSE-1:0] irq_cause;
   logic [MEM_AW-1:0] mem_addr;
   logic [MEM_DW-1:0] mem_wdata, mem_rdata;
   logic [NCH-1:0] done_irq;
   logic [40:0] wq[$];
   int miscompares, n_tests;
   int done_cnt[NCH];
   csdma_top uut (.clk(clk), .reset_n(reset_n), .cr_addr(cr_addr), .cr_wdata(cr_wdata), .cr_load(cr_load),
      .cr_read(cr_read), .cr_rdata(cr_rdata), .irq_cause(irq_cause), .cpu_hold(cpu_hold), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_word(mem_word), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .done_irq(done_irq), .hs_irq_block(hs_irq_block));
   csdma_mem u_mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (mem_wr)
         wq.push_back({mem_word, mem_addr, mem_wdata});
      for (int i = 0; i < NCH; i++)
         done_cnt[i] += int'(done_irq[i]);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cr_wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      cr_addr <= a;
      cr_wdata <= d;
      cr_load <= 1'b1;
      @(posedge clk);
      cr_load <= 1'b0;
   endtask
   task automatic cr_rd(logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      cr_addr <= a;
      cr_read <= 1'b1;
      @(posedge clk);
      cr_read <= 1'b0;
      #1 d = cr_rdata;
   endtask
   function automatic logic [31:0] ctl(logic [1:0] m, logic w, logic fd, logic [4:0] c, logic sw);
      return {18'h0, sw, c, 4'h0, fd, w, m};
   endfunction
   task automatic setup(int ch, logic [31:0] c, logic [31:0] cnt, logic [31:0] rel, logic [31:0] fw,
      logic [31:0] fx, logic [31:0] ar);
      logic [7:0] b;
      b = 8'(ch * 32);
      cr_wr(b | 8'(OFF_COUNT), cnt);
      cr_wr(b | 8'(OFF_RELOAD), rel);
      cr_wr(b | 8'(OFF_FWD), fw);
      cr_wr(b | 8'(OFF_FIX), fx);
      cr_wr(b | 8'(OFF_AREL), ar);
      cr_wr(b | 8'(OFF_CTRL), c);
   endtask
   task automatic pulse(int bitn);
      @(posedge clk);
      irq_cause <= NCAUSE'(1) << bitn;
      @(posedge clk);
      irq_cause <= '0;
   endtask
   task automatic wait_srv(int n);
      for (int k = 0; k < 40 && wq.size() < n; k++)
      begin
         @(posedge clk);
         #1;
      end
      check("services", 32'(wq.size()), 32'(n));
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic idle_check(int n);
      repeat (12) @(posedge clk);
      #1;
      check("no service", 32'(wq.size()), 32'(n));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_off();
      cr_rd(8'h04, rd);
      check("reset count", rd, 32'h0);
      cr_rd(8'h18, rd);
      check("unmapped read", rd, 32'h0);
      setup(0, ctl(MODE_OFF, 1'b0, 1'b0, CAUSE_SOFT, 1'b1), 32'h5, 32'h0, 32'h10, 32'h40, 32'h0);
      idle_check(0);
      cr_rd(8'h04, rd);
      check("count kept", rd, 32'h5);
      $display("test reset_off done");
   endtask
   task automatic t_single_byte();
      setup(0, ctl(MODE_SINGLE, 1'b0, 1'b0, CAUSE_SOFT, 1'b0), 32'h2, 32'h0, 32'h10, 32'h40, 32'h0);
      cr_wr(8'h00, ctl(MODE_SINGLE, 1'b0, 1'b0, CAUSE_SOFT, 1'b1));
      wait_srv(1);
      check("dest addr", 32'(wq[0][39:16]), 32'h40);
      check("byte data", 32'(wq[0][7:0]), 32'h10);
      cr_rd(8'h04, rd);
      check("count step", rd, 32'h1);
      cr_rd(8'h0C, rd);
      check("fwd step", rd, 32'h11);
      cr_rd(8'h00, rd);
      check("ctrl read", rd, 32'h1);
      check("byte unit", 32'(wq[0][40]), 32'h0);
      check("no early done", 32'(done_cnt[0]), 32'h0);
      cr_wr(8'h00, ctl(MODE_SINGLE, 1'b0, 1'b0, CAUSE_SOFT, 1'b1));
      wait_srv(2);
      check("done ch0", 32'(done_cnt[0]), 32'h1);
      cr_rd(8'h04, rd);
      check("count zero", rd, 32'h0);
      cr_wr(8'h00, ctl(MODE_SINGLE, 1'b0, 1'b0, CAUSE_SOFT, 1'b1));
      idle_check(2);
      $display("test single_byte done");
   endtask
   task automatic t_repeat_word();
      setup(1, ctl(MODE_REPEAT, 1'b1, 1'b1, 5'h03, 1'b0), 32'h1, 32'h2, 32'h20, 32'h50, 32'h30);
      pulse(3);
      wait_srv(3);
      check("word move", 32'(wq[2]), 32'h0020_A550);
      check("done ch1", 32'(done_cnt[1]), 32'h1);
      cr_rd(8'h24, rd);
      check("count reload", rd, 32'h2);
      cr_rd(8'h2C, rd);
      check("fwd reload", rd, 32'h30);
      check("word unit", 32'(wq[2][40]), 32'h1);
      cr_rd(8'h30, rd);
      check("fixed kept", rd, 32'h50);
      pulse(3);
      wait_srv(4);
      check("second dest", 32'(wq[3][39:16]), 32'h30);
      cr_rd(8'h2C, rd);
      check("word step", rd, 32'h32);
      cr_wr(8'h20, ctl(MODE_OFF, 1'b1, 1'b1, 5'h03, 1'b0));
      pulse(3);
      idle_check(4);
      $display("test repeat_word done");
   endtask
   task automatic t_priority();
      setup(3, ctl(MODE_SINGLE, 1'b0, 1'b0, 5'h04, 1'b0), 32'h1, 32'h0, 32'h0, 32'h64, 32'h0);
      setup(2, ctl(MODE_SINGLE, 1'b0, 1'b0, 5'h04, 1'b0), 32'h1, 32'h0, 32'h0, 32'h62, 32'h0);
      setup(0, ctl(MODE_SINGLE, 1'b0, 1'b0, 5'h04, 1'b0), 32'h1, 32'h0, 32'h0, 32'h60, 32'h0);
      check("hs block on", 32'(hs_irq_block), 32'h1);
      pulse(4);
      wait_srv(7);
      check("first ch0", 32'(wq[4][39:16]), 32'h60);
      check("then ch2", 32'(wq[5][39:16]), 32'h62);
      check("then ch3", 32'(wq[6][39:16]), 32'h64);
      cr_rd(8'h80, rd);
      check("status", rd, 32'hE);
      cr_wr(8'h40, 32'h0);
      cr_wr(8'h60, 32'h0);
      @(posedge clk);
      #1;
      check("hs block off", 32'(hs_irq_block), 32'h0);
      $display("test priority done");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset_n = 1'b0;
      cr_addr = '0;
      cr_wdata = '0;
      cr_load = 1'b0;
      cr_read = 1'b0;
      irq_cause = '0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_off();
      t_single_byte();
      t_repeat_word();
      t_priority();
      give_verdict();
   end
   initial
   begin
      #100000;
      miscompares++;
      give_verdict();
   end
endmodule // csdma_top_test
